/* File: logic/t3ar_pkg.sv */
/*
 * Shared constants and types for the auto-reload timer: register addresses,
 * control field layout, reset values and prescaler counts.
 * Assumes a byte-wide special-function register port on the system clock.
 */
package t3ar_pkg;

    // Control register address, and the addresses of the other byte registers.
    localparam logic [7:0] T3AR_ADDR_CTRL      = 8'h91;
    localparam logic [7:0] T3AR_ADDR_RELOAD_LO = 8'h92;
    localparam logic [7:0] T3AR_ADDR_RELOAD_HI = 8'h93;
    localparam logic [7:0] T3AR_ADDR_COUNT_LO  = 8'h94;
    localparam logic [7:0] T3AR_ADDR_COUNT_HI  = 8'h95;

    localparam logic [7:0]  T3AR_BYTE_MAX   = 8'hff;
    localparam logic [15:0] T3AR_WORD_MAX   = 16'hffff;
    localparam logic [7:0]  T3AR_BYTE_ONE   = 8'h01;
    localparam logic [15:0] T3AR_WORD_ONE   = 16'h0001;
    localparam logic [7:0]  T3AR_BYTE_ZERO  = 8'h00;
    localparam logic [15:0] T3AR_WORD_ZERO  = 16'h0000;
    localparam logic [7:0]  T3AR_CTRL_RESET = 8'h00;

    // Prescaler ratios.
    localparam int unsigned T3AR_SYS_DIV = 12;
    localparam int unsigned T3AR_EXT_DIV = 8;
    localparam logic [3:0]  T3AR_SYS_LAST = 4'(T3AR_SYS_DIV - 1);
    localparam logic [2:0]  T3AR_EXT_LAST = 3'(T3AR_EXT_DIV - 1);

    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_overflow_irq_enable;
        logic lfo_capture_enable;
        logic split_mode_select;
        logic run_control;
        logic unused_bit;
        logic external_clock_select;
    } t3ar_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } t3ar_sfr_req_t;

endpackage : t3ar_pkg

/* File: logic/t3ar_tick.sv */
/*
 * Count tick generator: system clock divided by twelve, and the external
 * oscillator divided by eight and brought onto the system clock.
 * Assumes the external oscillator runs well below half the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module t3ar_tick
    import t3ar_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ext_osc_i,
    output var  logic tick_div12_o,
    output var  logic tick_ext8_o
);

    logic [3:0] div12_q;
    logic [2:0] div8_q;
    logic       sync1_q;
    logic       sync2_q;
    logic       sync3_q;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div12_q      <= 4'h0;
            tick_div12_o <= 1'b0;
        end
        else
        begin
            tick_div12_o <= (div12_q == T3AR_SYS_LAST);
            div12_q      <= (div12_q == T3AR_SYS_LAST) ? 4'h0 : div12_q + 4'h1;
        end
    end

    // The second and third stages feed the edge detector.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end
        else
        begin
            sync1_q <= ext_osc_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div8_q      <= 3'h0;
            tick_ext8_o <= 1'b0;
        end
        else
        begin
            tick_ext8_o <= 1'b0;
            if (sync2_q && !sync3_q)
            begin
                div8_q      <= div8_q + 3'h1;
                tick_ext8_o <= (div8_q == T3AR_EXT_LAST);
            end
        end
    end

    sequence s_quiet8;
        (!tick_div12_o) [*8];
    endsequence

    property p_div12_period;
        @(posedge clk_i) disable iff (!rst_n_i)
        tick_div12_o |=> s_quiet8 ##4 tick_div12_o;
    endproperty
    a_div12_period: assert property (p_div12_period)
        else $error("div12 tick not every twelve cycles");

endmodule // t3ar_tick

`default_nettype wire

/* File: logic/t3ar_top.sv */
/*
 * Timer with 16-bit or split dual 8-bit auto-reload, its control,
 * reload and count byte registers, and its interrupt request.
 * Assumes the core drives the register port synchronously to CLOCK_I and
 * that clock selects and the interrupt enable come from logic on CLOCK_I.
 */
`timescale 1ns/1ps
`default_nettype none

module t3ar_top
    import t3ar_pkg::*;
(
    input  wire logic       CLOCK_I,
    input  wire logic       RESET_N_I,
    input  wire logic [7:0] SFR_ADDR_I,
    input  wire logic       SFR_WR_I,
    input  wire logic [7:0] SFR_WDATA_I,
    output var  logic [7:0] SFR_RDATA_O,
    input  wire logic       EXT_OSC_I,
    input  wire logic       LOW_BYTE_CLOCK_SEL_I,
    input  wire logic       HIGH_BYTE_CLOCK_SEL_I,
    input  wire logic       TIMER_IRQ_ENABLE_I,
    output var  logic       TIMER_IRQ_O
);

    t3ar_ctrl_t    ctrl_q;
    t3ar_sfr_req_t req;
    logic [15:0]   reload_q;
    logic [15:0]   count_q;
    logic [15:0]   count_d;
    logic          set_high;
    logic          set_low;
    logic          tick_div12;
    logic          tick_ext8;
    logic          tick_lo;
    logic          tick_hi;

    assign req = '{addr: SFR_ADDR_I, wr: SFR_WR_I, wdata: SFR_WDATA_I};

    function automatic logic wr_hit(input t3ar_sfr_req_t r,
                                    input logic [7:0]    a);
        return r.wr && (r.addr == a);
    endfunction

    function automatic logic pick_tick(input logic sel,
                                       input logic xclk,
                                       input logic t12,
                                       input logic t8);
        return sel ? 1'b1 : (xclk ? t8 : t12);
    endfunction

    t3ar_tick u_tick (
        .clk_i        (CLOCK_I),
        .rst_n_i      (RESET_N_I),
        .ext_osc_i    (EXT_OSC_I),
        .tick_div12_o (tick_div12),
        .tick_ext8_o  (tick_ext8)
    );

    // In 16-bit mode the low byte select clocks the whole count.
    assign tick_lo = pick_tick(LOW_BYTE_CLOCK_SEL_I,
                               ctrl_q.external_clock_select,
                               tick_div12, tick_ext8);
    assign tick_hi = pick_tick(HIGH_BYTE_CLOCK_SEL_I,
                               ctrl_q.external_clock_select,
                               tick_div12, tick_ext8);

    always_comb
    begin
        count_d  = count_q;
        set_high = 1'b0;
        set_low  = 1'b0;
        if (!ctrl_q.split_mode_select)
        begin
            if (ctrl_q.run_control && tick_lo)
            begin
                set_low = (count_q[7:0] == T3AR_BYTE_MAX);
                if (count_q == T3AR_WORD_MAX)
                begin
                    count_d  = reload_q;
                    set_high = 1'b1;
                end
                else
                begin
                    count_d = count_q + T3AR_WORD_ONE;
                end
            end
        end
        else
        begin
            if (tick_lo)
            begin
                if (count_q[7:0] == T3AR_BYTE_MAX)
                begin
                    count_d[7:0] = reload_q[7:0];
                    set_low      = 1'b1;
                end
                else
                begin
                    count_d[7:0] = count_q[7:0] + T3AR_BYTE_ONE;
                end
            end
            if (ctrl_q.run_control && tick_hi)
            begin
                if (count_q[15:8] == T3AR_BYTE_MAX)
                begin
                    count_d[15:8] = reload_q[15:8];
                    set_high      = 1'b1;
                end
                else
                begin
                    count_d[15:8] = count_q[15:8] + T3AR_BYTE_ONE;
                end
            end
        end
        // A software write to a count byte overrides that cycle's tick.
        if (wr_hit(req, T3AR_ADDR_COUNT_LO))
        begin
            count_d[7:0] = req.wdata;
        end
        if (wr_hit(req, T3AR_ADDR_COUNT_HI))
        begin
            count_d[15:8] = req.wdata;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            count_q <= T3AR_WORD_ZERO;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            reload_q <= T3AR_WORD_ZERO;
        end
        else
        begin
            if (wr_hit(req, T3AR_ADDR_RELOAD_LO))
            begin
                reload_q[7:0] <= req.wdata;
            end
            if (wr_hit(req, T3AR_ADDR_RELOAD_HI))
            begin
                reload_q[15:8] <= req.wdata;
            end
        end
    end

    // A hardware set in the same cycle as a clearing write still lands.
    always_ff @(posedge CLOCK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            ctrl_q <= T3AR_CTRL_RESET;
        end
        else
        begin
            if (wr_hit(req, T3AR_ADDR_CTRL))
            begin
                ctrl_q            <= req.wdata;
                ctrl_q.unused_bit <= 1'b0;
            end
            if (set_high)
            begin
                ctrl_q.high_overflow_flag <= 1'b1;
            end
            if (set_low)
            begin
                ctrl_q.low_overflow_flag <= 1'b1;
            end
        end
    end

    // The request is a level that follows the sticky flags.
    always_ff @(posedge CLOCK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            TIMER_IRQ_O <= 1'b0;
        end
        else
        begin
            TIMER_IRQ_O <= TIMER_IRQ_ENABLE_I &&
                (ctrl_q.high_overflow_flag ||
                 (ctrl_q.low_overflow_irq_enable &&
                  ctrl_q.low_overflow_flag));
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            SFR_RDATA_O <= T3AR_BYTE_ZERO;
        end
        else
        begin
            case (req.addr)
                T3AR_ADDR_CTRL:      SFR_RDATA_O <= ctrl_q;
                T3AR_ADDR_RELOAD_LO: SFR_RDATA_O <= reload_q[7:0];
                T3AR_ADDR_RELOAD_HI: SFR_RDATA_O <= reload_q[15:8];
                T3AR_ADDR_COUNT_LO:  SFR_RDATA_O <= count_q[7:0];
                T3AR_ADDR_COUNT_HI:  SFR_RDATA_O <= count_q[15:8];
                default:             SFR_RDATA_O <= T3AR_BYTE_ZERO;
            endcase
        end
    end

    logic cnt_wr;
    assign cnt_wr = wr_hit(req, T3AR_ADDR_COUNT_LO) ||
                    wr_hit(req, T3AR_ADDR_COUNT_HI);
    sequence s_wrap16;
        !ctrl_q.split_mode_select && ctrl_q.run_control && tick_lo &&
        (count_q == T3AR_WORD_MAX) && !cnt_wr;
    endsequence

    property p_wrap16_reload;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        s_wrap16 |=> (count_q == $past(reload_q));
    endproperty
    a_wrap16_reload: assert property (p_wrap16_reload)
        else $error("16-bit wrap did not load reload value");
    property p_wrap16_flag;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        s_wrap16 |=> ctrl_q.high_overflow_flag && ctrl_q.low_overflow_flag;
    endproperty
    a_wrap16_flag: assert property (p_wrap16_flag)
        else $error("16-bit wrap did not set overflow flags");
    property p_stop_hold;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        !ctrl_q.split_mode_select && !ctrl_q.run_control && !cnt_wr
        |=> $stable(count_q);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stopped 16-bit count changed");
    property p_add_one;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        !ctrl_q.split_mode_select && ctrl_q.run_control && tick_lo &&
        !cnt_wr && (count_q != T3AR_WORD_MAX)
        |=> (count_q == $past(count_q) + T3AR_WORD_ONE);
    endproperty
    a_add_one: assert property (p_add_one)
        else $error("enabled tick did not add one");
    property p_split_low_runs;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        ctrl_q.split_mode_select && !ctrl_q.run_control && tick_lo &&
        !cnt_wr && (count_q[7:0] == T3AR_BYTE_MAX)
        |=> (count_q[7:0] == $past(reload_q[7:0])) &&
            ctrl_q.low_overflow_flag && $stable(count_q[15:8]);
    endproperty
    a_split_low_runs: assert property (p_split_low_runs)
        else $error("split low byte did not reload while high held");
    property p_flag_sticky;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        ctrl_q.high_overflow_flag && !wr_hit(req, T3AR_ADDR_CTRL)
        |=> ctrl_q.high_overflow_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("high flag cleared without a write");
    property p_irq_follow;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        TIMER_IRQ_ENABLE_I && ctrl_q.low_overflow_irq_enable &&
        ctrl_q.low_overflow_flag |=> TIMER_IRQ_O;
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("low overflow did not request interrupt");
    property p_system_clock_tick;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        ctrl_q.split_mode_select && ctrl_q.run_control &&
        HIGH_BYTE_CLOCK_SEL_I && !cnt_wr && (count_q[15:8] != T3AR_BYTE_MAX)
        |=> (count_q[15:8] == $past(count_q[15:8]) + T3AR_BYTE_ONE);
    endproperty
    a_system_clock_tick: assert property (p_system_clock_tick)
        else $error("system clock select did not advance high byte");

endmodule // t3ar_top

`default_nettype wire

/* File: bench/t3ar_core_model.sv */
/*
 * Behavioural model of the processor core on the byte-wide register port.
 * Assumes the timer takes writes and read addresses on rising clock edges.
 */
`timescale 1ns/1ps
`default_nettype none

module t3ar_core_model
    import t3ar_pkg::*;
(
    input  wire logic       clk_i,
    output var  logic [7:0] addr_o,
    output var  logic       wr_o,
    output var  logic [7:0] wdata_o,
    input  wire logic [7:0] rdata_i
);
    initial
    begin
        addr_o  = 8'h00;
        wr_o    = 1'b0;
        wdata_o = 8'h00;
    end

    // The strobe lasts exactly one edge; stale data is inverted afterwards
    // so that a late sample of the data lines cannot look like a match.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o  = a;
        wdata_o = d;
        wr_o    = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o    = 1'b0;
        wdata_o = ~d;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask
endmodule // t3ar_core_model

`default_nettype wire

/* File: bench/tb.sv */
/*
 * Self-checking bench for the auto-reload timer: modes, clock sources,
 * flags, interrupt level and the control register.
 * Assumes the core model on the register port and a 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    import t3ar_pkg::*;
    logic        clk, rst_n, ext, lsel, hsel, irq_en, wr, irq;
    logic [7:0]  addr, wdata, rdata, d, d2, lo;
    logic [15:0] st, rl, ec;
    logic [8:0]  e8l, e8h;
    logic [17:0] e16;
    logic [31:0] r;
    logic        len, spl, run, hf, lf, hs;
    int          seed, failures, check_count, k;

    always #5 clk = ~clk;

    t3ar_core_model core_u (.clk_i(clk), .addr_o(addr), .wr_o(wr),
        .wdata_o(wdata), .rdata_i(rdata));
    t3ar_top dut_u (.CLOCK_I(clk), .RESET_N_I(rst_n), .SFR_ADDR_I(addr),
        .SFR_WR_I(wr), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata),
        .EXT_OSC_I(ext), .LOW_BYTE_CLOCK_SEL_I(lsel),
        .HIGH_BYTE_CLOCK_SEL_I(hsel), .TIMER_IRQ_ENABLE_I(irq_en),
        .TIMER_IRQ_O(irq));

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (failures == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    function automatic logic [8:0] f8(input logic [7:0] c,
                                      input logic [7:0] rv, input int n);
        logic f;
        f = 1'b0;
        for (int j = 0; j < n; j++)
        begin
            f = f | (c == 8'hff);
            c = (c == 8'hff) ? rv : c + 8'h01;
        end
        return {f, c};
    endfunction

    function automatic logic [17:0] f16(input logic [15:0] c,
                                        input logic [15:0] rv, input int n);
        logic h, l;
        h = 1'b0;
        l = 1'b0;
        for (int j = 0; j < n; j++)
        begin
            l = l | (c[7:0] == 8'hff);
            h = h | (c == 16'hffff);
            c = (c == 16'hffff) ? rv : c + 16'h0001;
        end
        return {h, l, c};
    endfunction

    // Runaway guard in case a handshake never completes.
    initial
    begin
        #500us;
        failures++;
        final_report();
    end

    initial
    begin
        seed = 32'h6531;
        failures = 0;
        check_count = 0;
        clk = 1'b0;
        rst_n = 1'b0;
        ext = 1'b0;
        lsel = 1'b0;
        hsel = 1'b0;
        irq_en = 1'b1;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        core_u.rd_reg(T3AR_ADDR_CTRL, d);
        check("ctrl_reset", {8'h00, d}, 16'h0000);
        core_u.wr_reg(T3AR_ADDR_CTRL, 8'h13);
        core_u.wr_reg(8'h90, 8'hff);
        core_u.rd_reg(T3AR_ADDR_CTRL, d);
        check("ctrl_bits", {8'h00, d}, 16'h0011);
        core_u.rd_reg(8'h90, d);
        check("unmapped", {8'h00, d}, 16'h0000);
        // Selecting the idle external source is how counting is paused
        // without a control write that would disturb the flags.
        core_u.wr_reg(T3AR_ADDR_CTRL, 8'h01);
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            len = i[0];
            spl = i[1];
            run = i[2];
            hs = r[7] | i[0];
            st = {7'h7f, r[8], 3'h7, r[4:0]};
            // Odd passes start on a wrap so every overflow path is reached.
            if (i[0]) st = {i[2] ? 8'hff : st[15:8], 8'hff};
            rl = r[31:16];
            k = 1 + int'(r[13:9]) + 10 * int'(r[15:14]);
            core_u.wr_reg(T3AR_ADDR_COUNT_LO, st[7:0]);
            core_u.wr_reg(T3AR_ADDR_COUNT_HI, st[15:8]);
            core_u.wr_reg(T3AR_ADDR_RELOAD_LO, rl[7:0]);
            core_u.wr_reg(T3AR_ADDR_RELOAD_HI, rl[15:8]);
            core_u.wr_reg(T3AR_ADDR_CTRL, {2'b00, len, 1'b0, spl, run, 2'b01});
            @(posedge clk);
            #1 lsel = 1'b1;
            hsel = hs;
            repeat (k) @(posedge clk);
            #1 lsel = 1'b0;
            hsel = 1'b0;
            if (spl)
            begin
                e8l = f8(st[7:0], rl[7:0], k);
                e8h = f8(st[15:8], rl[15:8], (run && hs) ? k : 0);
                ec = {e8h[7:0], e8l[7:0]};
                hf = e8h[8];
                lf = e8l[8];
            end
            else
            begin
                e16 = f16(st, rl, run ? k : 0);
                ec = e16[15:0];
                hf = e16[17];
                lf = e16[16];
            end
            core_u.rd_reg(T3AR_ADDR_COUNT_LO, lo);
            core_u.rd_reg(T3AR_ADDR_COUNT_HI, d);
            check("count", {d, lo},
                  ec);
            core_u.rd_reg(T3AR_ADDR_CTRL, d);
            ec = {8'h00, hf, lf, len, 1'b0, spl, run, 2'b01};
            check("flags", {8'h00, d}, ec);
            check("irq", {15'h0000, irq},
                  {15'h0000, hf | (len & lf)});
            irq_en = 1'b0;
            @(posedge clk);
            #1 check("irq_off", {15'h0000, irq}, 16'h0000);
            irq_en = 1'b1;
            core_u.wr_reg(T3AR_ADDR_CTRL, 8'h01);
            core_u.rd_reg(T3AR_ADDR_CTRL, d);
            check("flags_clr", {8'h00, d}, 16'h0001);
            check("irq_clr", {15'h0000, irq}, 16'h0000);
        end
        core_u.wr_reg(T3AR_ADDR_COUNT_LO, 8'h00);
        core_u.wr_reg(T3AR_ADDR_CTRL, 8'h04);
        repeat (120) @(posedge clk);
        core_u.wr_reg(T3AR_ADDR_CTRL, 8'h05);
        core_u.rd_reg(T3AR_ADDR_COUNT_LO, d);
        check("div12", {15'h0000, d == 8'h0a || d == 8'h0b},
              16'h0001);
        repeat (64)
        begin
            #40 ext = 1'b1;
            #40 ext = 1'b0;
        end
        repeat (10) @(posedge clk);
        core_u.rd_reg(T3AR_ADDR_COUNT_LO, d2);
        check("ext8", {8'h00, d2 - d}, 16'h0008);
        final_report();
    end
endmodule // tb

`default_nettype wire
